/* src/usbc_core.sv */
// status, baud-rate and break control of an asynchronous serial port
// assumes a cpu register port of single-cycle read/write strobes, and a
// shift datapath that reports frame events as one-cycle pulses
`timescale 1ns/10ps
module usbc_core import usbc_pkg::*; (
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic CLK_EN,
	// cpu register port
	input wire logic [`USBC_ADDR_W-1:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	// mode bits held in the port mode register
	input wire logic PORT_POWER_ENABLE,
	input wire logic TX_ENABLE,
	input wire logic RX_ENABLE,
	input wire logic [1:0] PARITY_MODE,
	// receive datapath events
	input wire logic RX_DONE,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_PARITY_BIT,
	input wire logic RX_STOP_BIT,
	input wire logic RX_BUFFER_READ,
	output logic [7:0] RX_BUFFER,
	// transmit datapath events
	input wire logic TX_BUFFER_WRITE,
	input wire logic TX_FRAME_END,
	output logic TX_LOAD,
	// break field
	input wire logic BREAK_RX_DONE,
	input wire logic BREAK_TX_DONE,
	output logic BREAK_RX_ACTIVE,
	output logic BREAK_TX_START,
	output logic [4:0] BREAK_LEN_BITS,
	output logic BIT_ORDER_SELECT,
	output logic TX_INVERT,
	// baud timing
	output logic BAUD_TICK,
	output logic BIT_TICK
);

	usbc_core_s st_reg;
	usbc_core_s st_next;

	// one address compare shared by the write and error-read strobe decodes
	function automatic logic addr_hit(input logic [`USBC_ADDR_W-1:0] a,
		input logic [`USBC_ADDR_W-1:0] reg_addr);
		addr_hit = (a == reg_addr);
	endfunction : addr_hit

	function automatic logic [4:0] brk_len_bits(input logic [2:0] code);
		brk_len_bits = (code >= `USBC_BRK_WRAP_CODE) ?
			(5'(code) + `USBC_BRK_LOW_BASE) : (5'(code) + `USBC_BRK_HIGH_BASE);
	endfunction : brk_len_bits

	function automatic logic par_error(input logic [1:0] mode, input logic [7:0] d,
		input logic pb);
		logic ones;
		ones = ^{d, pb};
		unique case (mode)
			`USBC_PAR_ODD: par_error = ~ones;
			`USBC_PAR_EVEN: par_error = ones;
			default: par_error = 1'b0;
		endcase
	endfunction : par_error

	logic rx_run;
	logic tx_run;
	logic wr_brk;
	logic rd_err;
	logic overrun;
	logic rx_take;
	logic load_now;

	always_comb begin
		// mode bits change rarely; read combinationally here as plain levels
		rx_run = PORT_POWER_ENABLE && RX_ENABLE;
		tx_run = PORT_POWER_ENABLE && TX_ENABLE;
		wr_brk = WR && addr_hit(ADDR, `USBC_ADDR_BRK);
		rd_err = RD && addr_hit(ADDR, `USBC_ADDR_RX_ERR);
		overrun = RX_DONE && rx_run && st_reg.rx_full && !RX_BUFFER_READ;
		rx_take = RX_DONE && rx_run && !overrun;
		load_now = tx_run && st_reg.tx_bf && (!st_reg.tx_sf || TX_FRAME_END);

		st_next = st_reg;
		st_next.tx_load = 1'b0;
		st_next.brk_tx_start = 1'b0;

		// receive error flags: a new event beats the read-clear
		if (rd_err) begin
			st_next.rx_err = '0;
		end
		if (RX_DONE && rx_run) begin
			if (par_error(PARITY_MODE, RX_DATA, RX_PARITY_BIT)) begin
				st_next.rx_err[`USBC_RX_PE_BIT] = 1'b1;
			end
			if (!RX_STOP_BIT) begin
				st_next.rx_err[`USBC_RX_FE_BIT] = 1'b1;
			end
		end
		if (overrun) begin
			st_next.rx_err[`USBC_RX_OVE_BIT] = 1'b1;
		end

		// receive buffer
		if (RX_BUFFER_READ) begin
			st_next.rx_full = 1'b0;
		end
		if (rx_take) begin
			st_next.rx_buf = RX_DATA;
			st_next.rx_full = 1'b1;
		end
		if (!RX_ENABLE) begin
			st_next.rx_full = 1'b0;
		end

		// transmit flags
		if (load_now) begin
			st_next.tx_load = 1'b1;
			st_next.tx_bf = 1'b0;
			st_next.tx_sf = 1'b1;
		end else if (TX_FRAME_END) begin
			st_next.tx_sf = 1'b0;
		end
		if (TX_BUFFER_WRITE && tx_run) begin
			st_next.tx_bf = 1'b1;
		end
		if (!tx_run) begin
			st_next.tx_bf = 1'b0;
			st_next.tx_sf = 1'b0;
			st_next.tx_load = 1'b0;
		end

		// clock select and divisor writes
		if (WR && addr_hit(ADDR, `USBC_ADDR_CLK_SEL)) begin
			st_next.clk_sel = WDATA[3:0];
		end
		if (WR && addr_hit(ADDR, `USBC_ADDR_DIV)) begin
			st_next.divisor = WDATA;
		end

		// break field control
		if (BREAK_RX_DONE) begin
			st_next.brk_active = 1'b0;
		end
		if (BREAK_TX_DONE) begin
			st_next.brk_tx_trig = 1'b0;
		end
		if (wr_brk) begin
			st_next.brk_len = WDATA[`USBC_BRK_LEN_HI:`USBC_BRK_LEN_LO];
			st_next.brk_bits = brk_len_bits(WDATA[`USBC_BRK_LEN_HI:`USBC_BRK_LEN_LO]);
			st_next.bit_order = WDATA[`USBC_BRK_DIR_BIT];
			st_next.tx_inv = WDATA[`USBC_BRK_INV_BIT];
			// trigger self-clears on completion, so rewriting 1 restarts
			if (WDATA[`USBC_BRK_RXT_BIT] && rx_run) begin
				st_next.brk_active = 1'b1;
			end
			if (WDATA[`USBC_BRK_TXT_BIT] && tx_run) begin
				st_next.brk_tx_trig = 1'b1;
				st_next.brk_tx_start = 1'b1;
			end
		end
		if (!rx_run) begin
			st_next.brk_active = 1'b0;
		end
		if (!tx_run) begin
			st_next.brk_tx_trig = 1'b0;
			st_next.brk_tx_start = 1'b0;
		end

		// power off clears the whole port state except configuration
		if (!PORT_POWER_ENABLE) begin
			st_next.rx_err = '0;
			st_next.rx_buf = `USBC_RST_RXBUF;
			st_next.rx_full = 1'b0;
			st_next.brk_active = 1'b0;
		end

		// read data, registered: answer one cycle after the strobe
		st_next.rdata = `USBC_RST_ZERO;
		if (RD) begin
			unique case (ADDR)
				`USBC_ADDR_RX_ERR: st_next.rdata = {5'h00, st_reg.rx_err};
				`USBC_ADDR_TX_STAT: st_next.rdata = {6'h00, st_reg.tx_bf, st_reg.tx_sf};
				`USBC_ADDR_CLK_SEL: st_next.rdata = {4'h0, st_reg.clk_sel};
				`USBC_ADDR_DIV: st_next.rdata = st_reg.divisor;
				`USBC_ADDR_BRK: st_next.rdata = {st_reg.brk_active, 2'h0, st_reg.brk_len,
					st_reg.bit_order, st_reg.tx_inv};
				default: st_next.rdata = `USBC_RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg.rx_err <= '0;
			st_reg.rx_buf <= `USBC_RST_RXBUF;
			st_reg.rx_full <= 1'b0;
			st_reg.tx_bf <= 1'b0;
			st_reg.tx_sf <= 1'b0;
			st_reg.tx_load <= 1'b0;
			st_reg.clk_sel <= 4'h0;
			st_reg.divisor <= `USBC_RST_DIV;
			st_reg.brk_active <= 1'b0;
			st_reg.brk_tx_trig <= 1'b0;
			st_reg.brk_tx_start <= 1'b0;
			st_reg.brk_len <= 3'(`USBC_RST_BRK >> `USBC_BRK_LEN_LO);
			st_reg.brk_bits <= `USBC_RST_BRK_BITS;
			st_reg.bit_order <= 1'b1;
			st_reg.tx_inv <= 1'b0;
			st_reg.rdata <= `USBC_RST_ZERO;
		end else if (CLK_EN) begin
			st_reg <= st_next;
		end
	end

	// counters clear to zero and stay there with the port powered down
	usbc_baud_gen u_baud (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.ce(CLK_EN),
		.run(PORT_POWER_ENABLE),
		.clk_sel(st_reg.clk_sel),
		.divisor(st_reg.divisor),
		.baud_tick(BAUD_TICK),
		.bit_tick(BIT_TICK)
	);

	assign RDATA = st_reg.rdata;
	assign RX_BUFFER = st_reg.rx_buf;
	assign TX_LOAD = st_reg.tx_load;
	assign BREAK_RX_ACTIVE = st_reg.brk_active;
	assign BREAK_TX_START = st_reg.brk_tx_start;
	assign BREAK_LEN_BITS = st_reg.brk_bits;
	assign BIT_ORDER_SELECT = st_reg.bit_order;
	assign TX_INVERT = st_reg.tx_inv;

endmodule : usbc_core

/* src/usbc_cfg.svh */
// register map, field positions, reset values and limits of the serial port
// status, baud and break control; included by the package
`ifndef USBC_CFG_SVH
`define USBC_CFG_SVH

// register addresses on the cpu side
`define USBC_ADDR_W 16
`define USBC_ADDR_RX_ERR 16'hFF93
`define USBC_ADDR_TX_STAT 16'hFF95
`define USBC_ADDR_CLK_SEL 16'hFF96
`define USBC_ADDR_DIV 16'hFF97
`define USBC_ADDR_BRK 16'hFF98

// reset values
`define USBC_RST_ZERO 8'h00
`define USBC_RST_DIV 8'hFF
`define USBC_RST_BRK 8'h16
`define USBC_RST_RXBUF 8'hFF
`define USBC_RST_BRK_BITS 5'h0D

// receive error status fields
`define USBC_RX_PE_BIT 2
`define USBC_RX_FE_BIT 1
`define USBC_RX_OVE_BIT 0

// transmit status fields
`define USBC_TX_BF_BIT 1
`define USBC_TX_SF_BIT 0

// break control fields
`define USBC_BRK_ACT_BIT 7
`define USBC_BRK_RXT_BIT 6
`define USBC_BRK_TXT_BIT 5
`define USBC_BRK_LEN_HI 4
`define USBC_BRK_LEN_LO 2
`define USBC_BRK_DIR_BIT 1
`define USBC_BRK_INV_BIT 0

// break length decode: codes 5..7 give 13..15, codes 0..4 give 16..20
`define USBC_BRK_WRAP_CODE 3'h5
`define USBC_BRK_LOW_BASE 5'h08
`define USBC_BRK_HIGH_BASE 5'h10

// clock select and divisor limits
`define USBC_SEL_MAX 4'hB
`define USBC_DIV_MIN 8'h08

// parity modes
`define USBC_PAR_ODD 2'h2
`define USBC_PAR_EVEN 2'h3

`endif

/* src/usbc_pkg.sv */
// types shared by the serial port status, baud and break control modules
// assumes usbc_cfg.svh is reachable on the include path
package usbc_pkg;
`include "usbc_cfg.svh"

	typedef struct packed {
		logic [10:0] pre_cnt;
		logic [7:0] div_cnt;
		logic half;
		logic baud_tick;
		logic bit_tick;
	} usbc_baud_s;

	typedef struct packed {
		logic [2:0] rx_err;
		logic [7:0] rx_buf;
		logic rx_full;
		logic tx_bf;
		logic tx_sf;
		logic tx_load;
		logic [3:0] clk_sel;
		logic [7:0] divisor;
		logic brk_active;
		logic brk_tx_trig;
		logic brk_tx_start;
		logic [2:0] brk_len;
		logic [4:0] brk_bits;
		logic bit_order;
		logic tx_inv;
		logic [7:0] rdata;
	} usbc_core_s;

endpackage : usbc_pkg

/* src/usbc_baud_gen.sv */
// base clock prescaler and 8-bit divisor counter
// assumes synchronous run control from the owning core; one clock domain
`timescale 1ns/10ps
module usbc_baud_gen import usbc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// control
	input wire logic run,
	input wire logic [3:0] clk_sel,
	input wire logic [7:0] divisor,
	// ticks
	output logic baud_tick,
	output logic bit_tick
);

	usbc_baud_s st_reg;
	usbc_baud_s st_next;

	// prohibited codes fall back to the nearest legal one
	function automatic logic [3:0] legal_sel(input logic [3:0] s);
		legal_sel = (s > `USBC_SEL_MAX) ? `USBC_SEL_MAX : s;
	endfunction : legal_sel

	function automatic logic [7:0] legal_div(input logic [7:0] d);
		legal_div = (d < `USBC_DIV_MIN) ? `USBC_DIV_MIN : d;
	endfunction : legal_div

	logic [10:0] pre_last;
	logic base_tick;
	logic [7:0] div_last;

	always_comb begin
		pre_last = 11'((12'h001 << legal_sel(clk_sel)) - 12'h001);
		base_tick = (st_reg.pre_cnt >= pre_last);
		div_last = legal_div(divisor) - 8'h01;
		st_next = st_reg;
		st_next.baud_tick = 1'b0;
		st_next.bit_tick = 1'b0;
		if (!run) begin
			st_next.pre_cnt = '0;
			st_next.div_cnt = '0;
			st_next.half = 1'b0;
		end else begin
			st_next.pre_cnt = base_tick ? 11'h000 : st_reg.pre_cnt + 11'h001;
			if (base_tick) begin
				// compare, not reload: rewriting the same value leaves the count alone
				if (st_reg.div_cnt >= div_last) begin
					st_next.div_cnt = '0;
					st_next.baud_tick = 1'b1;
					st_next.half = ~st_reg.half;
					st_next.bit_tick = st_reg.half;
				end else begin
					st_next.div_cnt = st_reg.div_cnt + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign baud_tick = st_reg.baud_tick;
	assign bit_tick = st_reg.bit_tick;

endmodule : usbc_baud_gen

/* verif/usbc_node.sv */
// far-side shifter model: holds each loaded byte for one frame of bit times
// assumes bit ticks and load pulses from the core, one clock
`timescale 1ns/10ps
module usbc_node (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// core side
	input wire logic bit_tick,
	input wire logic tx_load,
	input wire logic slow,
	output logic frame_end
);
	logic [3:0] cnt_reg;
	logic busy_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			frame_end <= 1'b0;
			if (tx_load) begin
				busy_reg <= 1'b1;
				cnt_reg <= 4'h0;
			end else if (busy_reg && cnt_reg == (slow ? 4'hB : 4'hA)) begin
				busy_reg <= 1'b0;
				frame_end <= 1'b1;
			end else if (busy_reg && bit_tick) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
endmodule : usbc_node

/* verif/usbc_core_monitor.sv */
// port checker of the status, baud and break control
// assumes one clock REF_CLK and async active-low RST_B
`timescale 1ns/10ps
module usbc_core_monitor (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire logic CLK_EN,
	// register port
	input wire logic [15:0] ADDR,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] WDATA,
	input wire logic [7:0] RDATA,
	// mode and events
	input wire logic PORT_POWER_ENABLE,
	input wire logic TX_ENABLE,
	input wire logic RX_ENABLE,
	input wire logic RX_DONE,
	input wire logic BREAK_RX_DONE,
	// watched outputs
	input wire logic [7:0] RX_BUFFER,
	input wire logic TX_LOAD,
	input wire logic BREAK_RX_ACTIVE,
	input wire logic BREAK_TX_START,
	input wire logic [4:0] BREAK_LEN_BITS,
	input wire logic BAUD_TICK,
	input wire logic BIT_TICK
);
	logic rd_err;
	logic brk_wr;
	assign rd_err = CLK_EN && RD && ADDR == 16'hFF93 && !RX_DONE;
	assign brk_wr = CLK_EN && WR && ADDR == 16'hFF98;
	function automatic logic [4:0] blen(input logic [2:0] c);
		return (c >= 3'h5) ? {2'h0, c} + 5'h08 : {2'h0, c} + 5'h10;
	endfunction : blen
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	err_clear_a: assert property (rd_err ##1 rd_err |=> RDATA == 8'h00)
		else $error("flags kept after read");
	err_bits_a: assert property (CLK_EN && RD && ADDR == 16'hFF93 |=> RDATA[7:3] == 5'h00)
		else $error("error status upper bits set");
	tx_bits_a: assert property (CLK_EN && RD && ADDR == 16'hFF95 |=> RDATA[7:2] == 6'h00)
		else $error("tx status upper bits set");
	load_pulse_a: assert property (CLK_EN && TX_LOAD |=> !TX_LOAD)
		else $error("load longer than one cycle");
	tx_off_a: assert property (!TX_ENABLE |=> !TX_LOAD)
		else $error("load with transmit off");
	pwr_off_a: assert property (CLK_EN && !PORT_POWER_ENABLE |=> RX_BUFFER == 8'hFF && !BREAK_RX_ACTIVE)
		else $error("power off not cleared");
	brk_rx_a: assert property (brk_wr && WDATA[6] && PORT_POWER_ENABLE && RX_ENABLE |=> BREAK_RX_ACTIVE)
		else $error("break receive not started");
	brk_tx_a: assert property (brk_wr && WDATA[5] && PORT_POWER_ENABLE && TX_ENABLE |=> BREAK_TX_START)
		else $error("break send not started");
	brk_done_a: assert property (CLK_EN && BREAK_RX_DONE && !(brk_wr && WDATA[6]) |=> !BREAK_RX_ACTIVE)
		else $error("break status not cleared");
	brk_len_a: assert property (brk_wr |=> BREAK_LEN_BITS == blen($past(WDATA[4:2])))
		else $error("break length wrong");
	baud_gap_a: assert property (BAUD_TICK |=> !BAUD_TICK [*7])
		else $error("baud tick too soon");
	bit_tick_a: assert property (BIT_TICK |-> BAUD_TICK)
		else $error("bit tick without baud tick");
	bit_gap_a: assert property (BIT_TICK |=> !BIT_TICK [*8])
		else $error("bit tick too soon");
	cover property (BIT_TICK);
	cover property (!CLK_EN && WR);
	cover property (rd_err ##1 rd_err);
	cover property (TX_LOAD);
	cover property (brk_wr && WDATA[6]);
endmodule : usbc_core_monitor
bind usbc_core usbc_core_monitor mon_u (.REF_CLK, .RST_B, .CLK_EN, .ADDR, .WR, .RD, .WDATA,
	.RDATA, .PORT_POWER_ENABLE, .TX_ENABLE, .RX_ENABLE, .RX_DONE, .BREAK_RX_DONE, .RX_BUFFER,
	.TX_LOAD, .BREAK_RX_ACTIVE, .BREAK_TX_START, .BREAK_LEN_BITS, .BAUD_TICK, .BIT_TICK);

/* verif/testbench.sv */
// self-checking bench of the serial port status, baud and break control
// assumes the core, its bound checker and the far-side node model
`timescale 1ns/10ps
module testbench;
	logic REF_CLK = 0, RST_B = 0, CLK_EN = 1, WR = 0, RD = 0, RX_DONE = 0, RX_PARITY_BIT = 0;
	logic RX_STOP_BIT = 1, RX_BUFFER_READ = 0, TX_BUFFER_WRITE = 0, BREAK_RX_DONE = 0;
	logic BREAK_TX_DONE = 0, PORT_POWER_ENABLE = 0, TX_ENABLE = 0, RX_ENABLE = 0, slow = 0;
	logic [15:0] ADDR = 0;
	logic [7:0] WDATA = 0, RX_DATA = 0, RDATA, RX_BUFFER;
	logic [1:0] PARITY_MODE = 0;
	logic TX_FRAME_END, TX_LOAD, BREAK_RX_ACTIVE, BREAK_TX_START, BAUD_TICK, BIT_TICK;
	logic BIT_ORDER_SELECT, TX_INVERT;
	logic [4:0] BREAK_LEN_BITS;
	logic [31:0] seed = 32'h63A5, r;
	int n_fail = 0, comparisons = 0, cycles = 0, i;
	always #12.5 REF_CLK = ~REF_CLK;
	usbc_core dut_u (.REF_CLK, .RST_B, .CLK_EN, .ADDR, .WR, .RD, .WDATA, .RDATA,
		.PORT_POWER_ENABLE, .TX_ENABLE, .RX_ENABLE, .PARITY_MODE, .RX_DONE, .RX_DATA,
		.RX_PARITY_BIT, .RX_STOP_BIT, .RX_BUFFER_READ, .RX_BUFFER, .TX_BUFFER_WRITE,
		.TX_FRAME_END, .TX_LOAD, .BREAK_RX_DONE, .BREAK_TX_DONE, .BREAK_RX_ACTIVE,
		.BREAK_TX_START, .BREAK_LEN_BITS, .BIT_ORDER_SELECT, .TX_INVERT, .BAUD_TICK, .BIT_TICK);
	usbc_node node_u (.clk(REF_CLK), .rst_b(RST_B), .bit_tick(BIT_TICK), .tx_load(TX_LOAD),
		.slow(slow), .frame_end(TX_FRAME_END));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] err(input logic [1:0] m, input logic [8:0] dp, input logic s);
		return {5'h00, m[1] && ((^dp) == m[0]), !s, 1'b0};
	endfunction : err
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		// one idle edge so back-to-back calls never re-raise a strobe at once
		@(negedge REF_CLK);
		ADDR = a;
		WDATA = d;
		WR = 1;
		@(negedge REF_CLK);
		WR = 0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge REF_CLK);
		ADDR = a;
		RD = 1;
		@(negedge REF_CLK);
		RD = 0;
		chk(RDATA, e);
	endtask : rd
	task automatic rx(input logic [7:0] d, input logic p, input logic s);
		@(negedge REF_CLK);
		RX_DATA = d;
		RX_PARITY_BIT = p;
		RX_STOP_BIT = s;
		RX_DONE = 1;
		@(negedge REF_CLK);
		RX_DONE = 0;
		RX_DATA = ~d;
	endtask : rx
	task automatic await(input logic fe);
		int n;
		n = 0;
		while ((fe ? TX_FRAME_END : TX_LOAD) !== 1'b1 && n < 400) begin
			@(negedge REF_CLK);
			n++;
		end
		chk({7'h00, n < 400}, 8'h01);
	endtask : await
	task automatic results;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	// bounded so a stuck handshake still reaches the report
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (5) @(negedge REF_CLK);
		RST_B = 1;
		rd(16'hFF93, 8'h00);
		rd(16'hFF95, 8'h00);
		rd(16'hFF97, 8'hFF);
		rd(16'hFF98, 8'h16);
		chk({6'h00, BIT_ORDER_SELECT, TX_INVERT}, 8'h02);
		chk({3'h0, BREAK_LEN_BITS}, 8'h0D);
		rd(16'hFF94, 8'h00);
		wr(16'hFF93, 8'hFF);
		rd(16'hFF93, 8'h00);
		r = xs();
		wr(16'hFF96, r[7:0]);
		rd(16'hFF96, {4'h0, r[3:0]});
		wr(16'hFF96, 8'h00);
		// frozen by the enable: this write must not land
		CLK_EN = 0;
		wr(16'hFF97, 8'h20);
		CLK_EN = 1;
		rd(16'hFF97, 8'hFF);
		wr(16'hFF97, 8'h08);
		PORT_POWER_ENABLE = 1;
		TX_ENABLE = 1;
		RX_ENABLE = 1;
		for (i = 0; i < 24; i++) begin
			r = xs();
			PARITY_MODE = i[1:0];
			rx(r[7:0], r[8], r[9]);
			chk(RX_BUFFER, r[7:0]);
			rd(16'hFF93, err(i[1:0], r[8:0], r[9]));
			RX_BUFFER_READ = 1;
			@(negedge REF_CLK);
			RX_BUFFER_READ = 0;
		end
		PARITY_MODE = 0;
		rx(r[15:8], 1'b0, 1'b1);
		rx(r[23:16], 1'b1, 1'b1);
		chk(RX_BUFFER, r[15:8]);
		ADDR = 16'hFF93;
		RD = 1;
		@(negedge REF_CLK);
		chk(RDATA, 8'h01);
		@(negedge REF_CLK);
		RD = 0;
		chk(RDATA, 8'h00);
		slow = r[24];
		TX_BUFFER_WRITE = 1;
		@(negedge REF_CLK);
		TX_BUFFER_WRITE = 0;
		await(1'b0);
		rd(16'hFF95, 8'h01);
		wr(16'hFF97, 8'h08);
		TX_BUFFER_WRITE = 1;
		@(negedge REF_CLK);
		TX_BUFFER_WRITE = 0;
		rd(16'hFF95, 8'h03);
		await(1'b0);
		rd(16'hFF95, 8'h01);
		await(1'b1);
		@(negedge REF_CLK);
		rd(16'hFF95, 8'h00);
		wr(16'hFF98, 8'h56);
		chk({7'h00, BREAK_RX_ACTIVE}, 8'h01);
		rd(16'hFF98, 8'h96);
		BREAK_RX_DONE = 1;
		@(negedge REF_CLK);
		BREAK_RX_DONE = 0;
		rd(16'hFF98, 8'h16);
		for (i = 0; i < 8; i++) begin
			wr(16'hFF98, {3'b001, i[2:0], 1'b1, i[0]});
			chk({7'h00, BREAK_TX_START}, 8'h01);
			chk({6'h00, BIT_ORDER_SELECT, TX_INVERT}, {6'h00, 1'b1, i[0]});
			chk({3'h0, BREAK_LEN_BITS}, (i < 5) ? 8'h10 + i[7:0] : 8'h08 + i[7:0]);
			BREAK_TX_DONE = 1;
			@(negedge REF_CLK);
			BREAK_TX_DONE = 0;
		end
		wr(16'hFF98, 8'h56);
		rx(r[31:24], 1'b0, 1'b0);
		PORT_POWER_ENABLE = 0;
		@(negedge REF_CLK);
		chk(RX_BUFFER, 8'hFF);
		rd(16'hFF93, 8'h00);
		rd(16'hFF98, 8'h16);
		results();
	end
endmodule : testbench
